//--- design/tsfb_pkg.sv
// constants, types and byte selection shared by the status frame builder
package tsfb_pkg;

   // frame framing
   localparam logic [7:0] TSFB_START_DELIM = 8'h7E;
   localparam logic [7:0] TSFB_TYPE_MODEM = 8'h8A;
   localparam logic [7:0] TSFB_TYPE_TXST = 8'h8B;
   localparam logic [7:0] TSFB_MODEM_POWERUP = 8'h00;
   localparam logic [15:0] TSFB_RSVD_FILL = 16'hFFFE;
   localparam logic [15:0] TSFB_LEN_MODEM = 16'h0002;
   localparam logic [15:0] TSFB_LEN_TXST = 16'h0007;
   localparam logic [7:0] TSFB_CK_BASE = 8'hFF;

   // byte positions inside a frame
   localparam logic [3:0] TSFB_POS_DELIM = 4'h0;
   localparam logic [3:0] TSFB_POS_LEN_HI = 4'h1;
   localparam logic [3:0] TSFB_POS_LEN_LO = 4'h2;
   localparam logic [3:0] TSFB_POS_TYPE = 4'h3;
   localparam logic [3:0] TSFB_POS_ID = 4'h4;
   localparam logic [3:0] TSFB_POS_RSVD_HI = 4'h5;
   localparam logic [3:0] TSFB_POS_RSVD_LO = 4'h6;
   localparam logic [3:0] TSFB_POS_RETRY = 4'h7;
   localparam logic [3:0] TSFB_POS_DELIV = 4'h8;
   localparam logic [3:0] TSFB_POS_DISC = 4'h9;
   localparam logic [3:0] TSFB_LAST_MODEM = 4'h5;
   localparam logic [3:0] TSFB_LAST_TXST = 4'hA;

   // delivery outcome codes
   localparam logic [7:0] TSFB_DLV_SUCCESS = 8'h00;
   localparam logic [7:0] TSFB_DLV_MAC_ACK = 8'h01;
   localparam logic [7:0] TSFB_DLV_CCA = 8'h02;
   localparam logic [7:0] TSFB_DLV_NO_SPECTRUM = 8'h03;
   localparam logic [7:0] TSFB_DLV_NET_ACK = 8'h21;
   localparam logic [7:0] TSFB_DLV_NO_ROUTE = 8'h25;
   localparam logic [7:0] TSFB_DLV_INT_RES = 8'h31;
   localparam logic [7:0] TSFB_DLV_NO_BUF = 8'h32;
   localparam logic [7:0] TSFB_DLV_TOO_LARGE = 8'h74;
   localparam logic [7:0] TSFB_DLV_UNREQ = 8'h75;

   // discovery codes
   localparam logic [7:0] TSFB_DISC_NONE = 8'h00;
   localparam logic [7:0] TSFB_DISC_ROUTE = 8'h02;

   // interface setting that selects the non-escaped framing
   localparam logic [1:0] TSFB_API_NOESC = 2'h1;

   // request queue: {frame id, retries, delivery, discovery}
   localparam int TSFB_REQ_W = 32;
   localparam int TSFB_FIFO_DEPTH = 8;
   localparam int TSFB_F_ID = 24;
   localparam int TSFB_F_RETRY = 16;
   localparam int TSFB_F_DELIV = 8;
   localparam int TSFB_F_DISC = 0;

   typedef enum logic [1:0] {
      TSFB_IDLE,
      TSFB_BOOT,
      TSFB_STAT
   } tsfb_state_e;

   // byte of the frame at a position; the checksum is supplied by the caller
   function automatic logic [7:0] tsfb_byte(input logic is_st, input logic [3:0] idx,
                                            input logic [7:0] id, input logic [7:0] retry,
                                            input logic [7:0] deliv, input logic [7:0] disc,
                                            input logic [7:0] ck);
      logic [15:0] len;
      logic [3:0] last;
      logic [7:0] b;
      len = is_st ? TSFB_LEN_TXST : TSFB_LEN_MODEM;
      last = is_st ? TSFB_LAST_TXST : TSFB_LAST_MODEM;
      b = 8'h00;
      if (idx == last) begin
         b = ck;
      end else begin
         case (idx)
            TSFB_POS_DELIM: b = TSFB_START_DELIM;
            TSFB_POS_LEN_HI: b = len[15:8];
            TSFB_POS_LEN_LO: b = len[7:0];
            TSFB_POS_TYPE: b = is_st ? TSFB_TYPE_TXST : TSFB_TYPE_MODEM;
            TSFB_POS_ID: b = is_st ? id : TSFB_MODEM_POWERUP;
            TSFB_POS_RSVD_HI: b = TSFB_RSVD_FILL[15:8];
            TSFB_POS_RSVD_LO: b = TSFB_RSVD_FILL[7:0];
            TSFB_POS_RETRY: b = retry;
            TSFB_POS_DELIV: b = deliv;
            TSFB_POS_DISC: b = disc;
            default: b = 8'h00;
         endcase
      end
      return b;
   endfunction

endpackage

//--- design/tsfb_fifo.sv
// request queue with valid/ready on both sides
`timescale 1ns/100ps
module tsfb_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_r;
   logic [AW-1:0] rptr_r;
   logic [AW:0] count_r;

   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = count_r != DEPTH[AW:0];
   assign out_valid_o = count_r != '0;
   assign out_data_o = mem[rptr_r];

   // pointers wrap naturally only for power-of-two depths
   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wptr_r <= '0;
         rptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wptr_r <= bump(wptr_r);
         end
         if (pop) begin
            rptr_r <= bump(rptr_r);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule

//--- design/tsfb_cksum.sv
// running 8-bit sum of the checksummed bytes and the resulting check byte
`timescale 1ns/100ps
module tsfb_cksum
   import tsfb_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // control
   input wire logic clr_i,
   input wire logic add_i,
   input wire logic [7:0] byte_i,
   // result
   output logic [7:0] sum_o,
   output logic [7:0] ck_o
);
   logic [7:0] sum_r;

   assign sum_o = sum_r;
   // carries out of bit 7 are dropped on purpose
   assign ck_o = TSFB_CK_BASE - sum_r;

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sum_r <= 8'h00;
      end else if (clr_i) begin
         sum_r <= 8'h00;
      end else if (add_i) begin
         sum_r <= sum_r + byte_i;
      end
   end

endmodule

//--- design/tsfb_frame_builder.sv
// status frame builder: boot frame after reset, transmit status frame per finished request with a nonzero identifier in the non-escaped setting
`timescale 1ns/100ps

// Operation
// - boot frame: type 8A, status 00
// - modem status code sits at byte 4
// - each finished request with a nonzero identifier yields one status frame once the non-escaped setting is selected
// - zero frame identifier suppresses the frame
// - broadcasts always report delivery 00
// - delimiter byte 0, length at bytes 1-2
// - type 8B at byte 3
// - request identifier copied to byte 4
// - bytes 5-6 hold FFFE, host ignores
// - byte 7 holds retry count
// - byte 8 holds delivery outcome code
// - byte 9 holds discovery code
// - last byte is FF minus sum
module tsfb_frame_builder
   import tsfb_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // configuration
   input wire logic [1:0] api_escape_setting_i,
   // finished transmit request
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [7:0] req_frame_id_i,
   input wire logic [7:0] req_retry_i,
   input wire logic [7:0] req_delivery_i,
   input wire logic [7:0] req_discovery_i,
   input wire logic req_broadcast_i,
   // serial byte stream towards the host
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [7:0] tx_data_o,
   // status
   output logic busy_o
);
   import tsfb_pkg::*;

   tsfb_state_e state_r;
   tsfb_state_e state_nxt;
   logic [3:0] idx_r;
   logic [3:0] idx_nxt;
   logic [7:0] id_r;
   logic [7:0] retry_r;
   logic [7:0] deliv_r;
   logic [7:0] disc_r;
   logic boot_pend_r;
   logic [7:0] tx_data_r;
   logic tx_valid_r;

   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [TSFB_REQ_W-1:0] fifo_wdata;
   logic fifo_out_valid;
   logic [TSFB_REQ_W-1:0] fifo_rdata;
   logic [7:0] ck_sum;
   logic [7:0] ck_val;

   // decoding
   wire busy = state_r != TSFB_IDLE;
   wire is_st = state_r == TSFB_STAT;
   wire load = busy && (!tx_valid_r || tx_ready_i);
   wire [3:0] last_idx = is_st ? TSFB_LAST_TXST : TSFB_LAST_MODEM;
   wire at_last = idx_r == last_idx;
   // escaping is not done here, so queued status frames wait for the plain setting
   wire api_ok = api_escape_setting_i == TSFB_API_NOESC;
   wire start_boot = !busy && boot_pend_r;
   wire start_stat = !busy && !boot_pend_r && fifo_out_valid && api_ok;
   wire ck_add = load && (idx_r >= TSFB_POS_TYPE) && !at_last;
   wire [7:0] next_byte = tsfb_byte(is_st, idx_r, id_r, retry_r, deliv_r, disc_r,
                                    ck_val);
   wire [7:0] deliv_in = req_broadcast_i ? TSFB_DLV_SUCCESS : req_delivery_i;

   // a zero identifier is taken from the port but never queued
   assign fifo_in_valid = req_valid_i && (req_frame_id_i != 8'h00);
   assign req_ready_o = fifo_in_ready;
   assign fifo_wdata = {req_frame_id_i, req_retry_i, deliv_in, req_discovery_i};

   assign tx_valid_o = tx_valid_r;
   assign tx_data_o = tx_data_r;
   assign busy_o = busy || boot_pend_r;

   tsfb_fifo #(
      .W(TSFB_REQ_W),
      .DEPTH(TSFB_FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_wdata),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(start_stat),
      .out_data_o(fifo_rdata)
   );

   tsfb_cksum u_cksum (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .clr_i(start_boot || start_stat),
      .add_i(ck_add),
      .byte_i(next_byte),
      .sum_o(ck_sum),
      .ck_o(ck_val)
   );

   // sequencing
   always_comb begin
      state_nxt = state_r;
      idx_nxt = idx_r;
      case (state_r)
         TSFB_IDLE: begin
            idx_nxt = TSFB_POS_DELIM;
            if (start_boot) begin
               state_nxt = TSFB_BOOT;
            end else if (start_stat) begin
               state_nxt = TSFB_STAT;
            end
         end
         TSFB_BOOT, TSFB_STAT: begin
            if (load) begin
               idx_nxt = idx_r + 4'h1;
               if (at_last) begin
                  state_nxt = TSFB_IDLE;
               end
            end
         end
         default: begin
            state_nxt = TSFB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= TSFB_IDLE;
         idx_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         idx_r <= idx_nxt;
      end
   end

   // power-up leaves exactly one boot frame owed
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         boot_pend_r <= 1'b1;
      end else if (start_boot) begin
         boot_pend_r <= 1'b0;
      end
   end

   // fields held for the whole frame so the queue may refill meanwhile
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         id_r <= 8'h00;
         retry_r <= 8'h00;
         deliv_r <= 8'h00;
         disc_r <= 8'h00;
      end else if (start_stat) begin
         id_r <= fifo_rdata[TSFB_F_ID +: 8];
         retry_r <= fifo_rdata[TSFB_F_RETRY +: 8];
         deliv_r <= fifo_rdata[TSFB_F_DELIV +: 8];
         disc_r <= fifo_rdata[TSFB_F_DISC +: 8];
      end
   end

   // output byte register: a byte stands until the host takes it
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_valid_r <= 1'b0;
         tx_data_r <= 8'h00;
      end else if (load) begin
         tx_valid_r <= 1'b1;
         tx_data_r <= next_byte;
      end else if (tx_ready_i) begin
         tx_valid_r <= 1'b0;
      end
   end

   // checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   property p_delim;
      load && idx_r == TSFB_POS_DELIM |=> tx_data_r == TSFB_START_DELIM;
   endproperty
   a_delim: assert property (p_delim)
      else $error("frame does not open with the start delimiter");

   property p_length;
      load && idx_r == TSFB_POS_LEN_HI ##1 load [*1]
         |=> tx_data_r == (is_st ? TSFB_LEN_TXST[7:0] : TSFB_LEN_MODEM[7:0])
             && $past(tx_data_r, 1) == 8'h00;
   endproperty
   a_length: assert property (p_length)
      else $error("length field wrong or not most significant byte first");

   property p_boot_type;
      load && state_r == TSFB_BOOT && idx_r == TSFB_POS_TYPE |=> tx_data_r == TSFB_TYPE_MODEM;
   endproperty
   a_boot_type: assert property (p_boot_type)
      else $error("boot frame type byte wrong");

   property p_boot_status;
      load && state_r == TSFB_BOOT && idx_r == TSFB_POS_ID |=> tx_data_r == TSFB_MODEM_POWERUP;
   endproperty
   a_boot_status: assert property (p_boot_status)
      else $error("boot frame status byte is not power-up");

   property p_boot_first;
      $rose(boot_pend_r == 1'b0) |-> $past(state_r == TSFB_IDLE) && state_r == TSFB_BOOT;
   endproperty
   a_boot_first: assert property (p_boot_first)
      else $error("boot pending cleared without starting the boot frame");

   property p_st_type;
      load && is_st && idx_r == TSFB_POS_TYPE |=> tx_data_r == TSFB_TYPE_TXST;
   endproperty
   a_st_type: assert property (p_st_type)
      else $error("status frame type byte wrong");

   property p_st_id;
      load && is_st && idx_r == TSFB_POS_ID |=> tx_data_r == $past(id_r) && tx_data_r != 8'h00;
   endproperty
   a_st_id: assert property (p_st_id)
      else $error("status frame identifier wrong or zero");

   property p_st_rsvd;
      load && is_st && idx_r == TSFB_POS_RSVD_LO
         |=> tx_data_r == TSFB_RSVD_FILL[7:0] && $past(tx_data_r) == TSFB_RSVD_FILL[15:8];
   endproperty
   a_st_rsvd: assert property (p_st_rsvd)
      else $error("reserved field is not FFFE");

   property p_st_retry;
      load && is_st && idx_r == TSFB_POS_RETRY |=> tx_data_r == $past(retry_r);
   endproperty
   a_st_retry: assert property (p_st_retry)
      else $error("retry count byte wrong");

   property p_st_deliv;
      load && is_st && idx_r == TSFB_POS_DELIV |=> tx_data_r == $past(deliv_r);
   endproperty
   a_st_deliv: assert property (p_st_deliv)
      else $error("delivery status byte wrong");

   property p_st_disc;
      load && is_st && idx_r == TSFB_POS_DISC |=> tx_data_r == $past(disc_r);
   endproperty
   a_st_disc: assert property (p_st_disc)
      else $error("discovery status byte wrong");

   property p_bcast;
      fifo_in_valid && fifo_in_ready && req_broadcast_i
         |-> fifo_wdata[TSFB_F_DELIV +: 8] == TSFB_DLV_SUCCESS;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("broadcast queued with nonzero delivery status");

   property p_zero_id;
      req_valid_i && req_frame_id_i == 8'h00 |-> !fifo_in_valid;
   endproperty
   a_zero_id: assert property (p_zero_id)
      else $error("zero identifier request was queued");

   property p_start_stat;
      !busy && !boot_pend_r && fifo_out_valid && api_ok |=> state_r == TSFB_STAT && idx_r == 4'h0;
   endproperty
   a_start_stat: assert property (p_start_stat)
      else $error("queued request did not start a status frame");

   property p_cksum;
      load && at_last |=> tx_data_r == 8'(TSFB_CK_BASE - $past(ck_sum));
   endproperty
   a_cksum: assert property (p_cksum)
      else $error("checksum byte wrong");

   property p_hold;
      tx_valid_r && !tx_ready_i |=> tx_valid_r && $stable(tx_data_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output byte changed before it was taken");

   property p_api_gate;
      $rose(is_st) |-> $past(api_ok);
   endproperty
   a_api_gate: assert property (p_api_gate)
      else $error("status frame started while escaped framing was selected");

   property p_boot_once;
      !boot_pend_r && state_r != TSFB_BOOT |=> state_r != TSFB_BOOT;
   endproperty
   a_boot_once: assert property (p_boot_once)
      else $error("boot frame sent a second time");

endmodule

//--- test/tsfb_host_model.sv
// host side of the serial link: takes frame bytes, can stall, verifies each frame
`timescale 1ns/100ps
module tsfb_host_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // pacing
   input wire logic slow_i,
   // byte stream from the builder
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o
);
   logic [7:0] got_q[$];
   int bad_cnt = 0;
   int idx;
   logic [15:0] len;
   logic [7:0] sum;
   logic [1:0] ph;

   // slow mode accepts one cycle in four so the builder has to hold its bytes
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_ready_o <= 1'b0;
         ph <= 2'h0;
         idx = 0;
         len = 16'h0000;
         sum = 8'h00;
      end else begin
         ph <= ph + 2'h1;
         tx_ready_o <= !slow_i || (ph == 2'h3);
         if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_data_i);
            if (idx == 0) begin
               if (tx_data_i !== 8'h7E) begin
                  bad_cnt++;
               end
               sum = 8'h00;
               idx = 1;
            end else if (idx == 1) begin
               len[15:8] = tx_data_i;
               idx = 2;
            end else if (idx == 2) begin
               len[7:0] = tx_data_i;
               idx = 3;
            end else if (idx == int'(len) + 3) begin
               if (tx_data_i !== 8'hFF - sum) begin
                  bad_cnt++;
               end
               idx = 0;
            end else begin
               sum = sum + tx_data_i;
               idx++;
            end
         end
      end
   end
endmodule

//--- test/tsfb_frame_builder_tb.sv
// self-checking bench for the status frame builder
`timescale 1ns/100ps
module tsfb_frame_builder_tb;
   import tsfb_pkg::*;

   logic core_clk, arst_n, req_valid, req_ready, req_bcast, tx_valid, tx_ready, busy, slow;
   logic [1:0] api_set;
   logic [7:0] req_id, req_retry, req_deliv, req_disc, tx_data;
   logic [7:0] exp_q[$];
   int error_cnt = 0;
   int checks = 0;
   localparam logic [7:0] CODES [10] = '{TSFB_DLV_SUCCESS, TSFB_DLV_MAC_ACK, TSFB_DLV_CCA,
      TSFB_DLV_NO_SPECTRUM, TSFB_DLV_NET_ACK, TSFB_DLV_NO_ROUTE, TSFB_DLV_INT_RES,
      TSFB_DLV_NO_BUF, TSFB_DLV_TOO_LARGE, TSFB_DLV_UNREQ};

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   tsfb_frame_builder i_tsfb_frame_builder (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .api_escape_setting_i(api_set),
      .req_valid_i(req_valid), .req_ready_o(req_ready), .req_frame_id_i(req_id),
      .req_retry_i(req_retry), .req_delivery_i(req_deliv), .req_discovery_i(req_disc),
      .req_broadcast_i(req_bcast), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .tx_data_o(tx_data), .busy_o(busy));

   tsfb_host_model i_tsfb_host_model (
      .core_clk_i(core_clk), .arst_n_i(arst_n), .slow_i(slow), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_ready_o(tx_ready));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // expected bytes are appended so several queued frames can be judged at once
   task automatic mk_stat(input logic [7:0] id, r, d, di);
      logic [7:0] s;
      s = 8'h8B + id + 8'hFF + 8'hFE + r + d + di;
      exp_q = {exp_q, 8'h7E, 8'h00, 8'h07, 8'h8B, id, 8'hFF, 8'hFE, r, d, di, 8'hFF - s};
   endtask

   // quiet tail catches any surplus frame
   task automatic expect_frames();
      int n;
      n = 0;
      while (i_tsfb_host_model.got_q.size() < exp_q.size() && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
      repeat (30) @(posedge core_clk);
      check(16'(i_tsfb_host_model.got_q.size()), 16'(exp_q.size()));
      while (exp_q.size() > 0 && i_tsfb_host_model.got_q.size() > 0) begin
         check(i_tsfb_host_model.got_q.pop_front(), exp_q.pop_front());
      end
      exp_q.delete();
      i_tsfb_host_model.got_q.delete();
   endtask

   // caller is aligned to a rising edge; valid stays up so requests can follow back to back
   // ready is sampled mid-cycle, where it has settled, so the taking edge is known exactly
   task automatic send_req(input logic [7:0] id, r, d, di, input logic b);
      int n;
      logic rdy;
      n = 0;
      rdy = 1'b0;
      req_valid <= 1'b1;
      req_id <= id;
      req_retry <= r;
      req_deliv <= d;
      req_disc <= di;
      req_bcast <= b;
      while (rdy !== 1'b1 && n < 2000) begin
         @(negedge core_clk);
         rdy = req_ready;
         @(posedge core_clk);
         n++;
      end
      check(rdy, 16'h0001);
   endtask

   task automatic req_idle();
      req_valid <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic t_boot();
      exp_q = {8'h7E, 8'h00, 8'h02, 8'h8A, 8'h00, 8'h75};
      expect_frames();
      check(busy, 16'h0000);
      $display("boot frame test done");
   endtask

   task automatic t_status();
      send_req(8'h11, 8'h02, TSFB_DLV_NET_ACK, TSFB_DISC_ROUTE, 1'b0);
      req_idle();
      mk_stat(8'h11, 8'h02, TSFB_DLV_NET_ACK, TSFB_DISC_ROUTE);
      expect_frames();
      $display("status frame test done");
   endtask

   task automatic t_zero_id();
      send_req(8'h00, 8'h01, TSFB_DLV_MAC_ACK, TSFB_DISC_NONE, 1'b0);
      send_req(8'h05, 8'h00, TSFB_DLV_SUCCESS, TSFB_DISC_NONE, 1'b0);
      req_idle();
      mk_stat(8'h05, 8'h00, TSFB_DLV_SUCCESS, TSFB_DISC_NONE);
      expect_frames();
      $display("zero identifier test done");
   endtask

   task automatic t_bcast();
      send_req(8'h33, 8'h01, TSFB_DLV_NO_ROUTE, TSFB_DISC_NONE, 1'b1);
      send_req(8'h34, 8'h01, TSFB_DLV_NO_ROUTE, TSFB_DISC_NONE, 1'b0);
      req_idle();
      mk_stat(8'h33, 8'h01, TSFB_DLV_SUCCESS, TSFB_DISC_NONE);
      mk_stat(8'h34, 8'h01, TSFB_DLV_NO_ROUTE, TSFB_DISC_NONE);
      expect_frames();
      $display("broadcast test done");
   endtask

   // frames held back by the setting fill the queue; then all codes drain to a stalling host
   task automatic t_fill();
      logic [7:0] di;
      slow <= 1'b1;
      api_set <= 2'h3;
      for (int i = 0; i < 10; i++) begin
         if (i == 8) begin
            repeat (20) @(posedge core_clk);
            check(req_ready, 16'h0000);
            check(16'(i_tsfb_host_model.got_q.size()), 16'h0000);
            api_set <= 2'h1;
         end
         di = i[0] ? TSFB_DISC_ROUTE : TSFB_DISC_NONE;
         send_req(8'(i + 1), 8'(i), CODES[i], di, 1'b0);
         mk_stat(8'(i + 1), 8'(i), CODES[i], di);
      end
      req_idle();
      expect_frames();
      slow <= 1'b0;
      $display("queue fill and code sweep test done");
   endtask

   initial begin
      #(1000000);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      arst_n = 1'b0;
      req_valid = 1'b0;
      req_id = 8'h00;
      req_retry = 8'h00;
      req_deliv = 8'h00;
      req_disc = 8'h00;
      req_bcast = 1'b0;
      api_set = 2'h1;
      slow = 1'b0;
      repeat (10) @(posedge core_clk);
      check(busy, 16'h0001);
      check(req_ready, 16'h0001);
      check(tx_valid, 16'h0000);
      arst_n <= 1'b1;
      t_boot();
      t_status();
      t_zero_id();
      t_bcast();
      t_fill();
      check(16'(i_tsfb_host_model.bad_cnt), 16'h0000);
      report_and_stop();
   end
endmodule
